// [modbus_rtu_pkg.sv]
// Shared constants and types for the RTU master framer
package modbus_rtu_pkg;
  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int HALF_MS_NS = 500000;
  localparam int HALF_MS_CYCLES =
    (HALF_MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] BAUD_SEL_MAX = 4'h8;
  // ---------------------------------------------------------------
  // Frame layout
  // ---------------------------------------------------------------
  localparam logic [7:0] BCAST_ADDR = 8'h00;
  localparam logic [7:0] EXC_FLAG = 8'h80;
  localparam logic [8:0] MIN_FRAME = 9'h004;
  localparam logic [8:0] EXC_FRAME = 9'h005;
  localparam logic [8:0] RX_DEPTH = 9'h100;
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [15:0] CRC_POLY = 16'hA001;
  // ---------------------------------------------------------------
  // Function codes
  // ---------------------------------------------------------------
  localparam logic [7:0] FC_RD_COILS = 8'h01;
  localparam logic [7:0] FC_RD_INPUTS = 8'h02;
  localparam logic [7:0] FC_RD_HOLD = 8'h03;
  localparam logic [7:0] FC_RD_INREG = 8'h04;
  localparam logic [7:0] FC_WR_COIL = 8'h05;
  localparam logic [7:0] FC_WR_REG = 8'h06;
  localparam logic [7:0] FC_RD_EXC = 8'h07;
  localparam logic [7:0] FC_LOOPBACK = 8'h08;
  localparam logic [7:0] FC_EVT_CNT = 8'h0B;
  localparam logic [7:0] FC_EVT_LOG = 8'h0C;
  localparam logic [7:0] FC_WR_COILS = 8'h0F;
  localparam logic [7:0] FC_WR_REGS = 8'h10;
  // ---------------------------------------------------------------
  // Job error codes; 1 to 7 mirror the slave exception code
  // ---------------------------------------------------------------
  localparam logic [3:0] ERR_NONE = 4'h0;
  localparam logic [3:0] EXC_MIN = 4'h1;
  localparam logic [3:0] EXC_MAX = 4'h7;
  localparam logic [3:0] ERR_TIMEOUT = 4'h8;
  localparam logic [3:0] ERR_CRC = 4'h9;
  localparam logic [3:0] ERR_REQUEST = 4'hA;
  localparam logic [3:0] ERR_FRAME = 4'hB;

  typedef enum logic [8:0] {
    ST_INIT = 9'h001,
    ST_PARAM = 9'h002,
    ST_IDLE = 9'h004,
    ST_SEND = 9'h008,
    ST_DRAIN = 9'h010,
    ST_WAIT = 9'h020,
    ST_RECV = 9'h040,
    ST_CHECK = 9'h080,
    ST_DELIVER = 9'h100
  } state_type;

  function automatic logic fc_supported(input logic [7:0] f);
    case (f)
      FC_RD_COILS, FC_RD_INPUTS, FC_RD_HOLD, FC_RD_INREG, FC_WR_COIL,
      FC_WR_REG, FC_RD_EXC, FC_LOOPBACK, FC_EVT_CNT, FC_EVT_LOG,
      FC_WR_COILS, FC_WR_REGS: fc_supported = 1'b1;
      default: fc_supported = 1'b0;
    endcase
  endfunction

  function automatic logic fc_bcast_ok(input logic [7:0] f);
    case (f)
      FC_WR_COIL, FC_WR_REG, FC_WR_COILS, FC_WR_REGS: fc_bcast_ok = 1'b1;
      default: fc_bcast_ok = 1'b0;
    endcase
  endfunction
endpackage

// [crc16_byte_step.sv]
// One byte step of the frame checksum, reflected form
`timescale 1ns/10ps
`default_nettype none
module crc16_byte_step
  import modbus_rtu_pkg::*;
(
  input wire logic [15:0] i_crc,
  input wire logic [7:0] i_byte,
  output logic [15:0] o_crc
);
  logic [15:0] work;

  // Polynomial x^16+x^15+x^2+1 shifted LSB first
  always_comb begin
    work = i_crc ^ {8'h00, i_byte};
    for (int b = 0; b < 8; b++) begin
      work = work[0] ? ((work >> 1) ^ CRC_POLY) : (work >> 1);
    end
    o_crc = work;
  end
endmodule // crc16_byte_step
`default_nettype wire

// [modbus_rtu_master_framer.sv]
// RTU master framer: request build, reply wait, frame end and check
// Functional notes
// - Master starts exchange, waits bounded reply time
// - Frame: address, function, data, two-byte checksum
// - Unicast request addresses one slave, 1..255
// - Address zero reaches all slaves
// - Broadcast only with write codes 5,6,15,16
// - No reply expected after broadcast
// - Supports codes 1-8, 11, 12, 15, 16
// - Checksum is CRC-16, x16+x15+x2+1
// - Checksum low byte sent first
// - 3.5 character silence ends received frame
// - Silence timeout 0.5 ms doubling per halved rate
// - Normal mode checks reply after silence only
// - Suppression mode ends frame on good checksum
// - Half duplex, no handshake pacing the line
// - Ready only after self test and parameters
// - Exception reply: job error, code, no data
`timescale 1ns/10ps
`default_nettype none
module modbus_rtu_master_framer
  import modbus_rtu_pkg::*;
#(
  parameter int P_HALF_MS_CYCLES = HALF_MS_CYCLES
) (
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  input wire logic i_selftest_done,
  input wire logic i_param_load,
  input wire logic [3:0] i_cfg_baud_sel,
  input wire logic i_cfg_suppress,
  input wire logic [15:0] i_cfg_reply_ms,
  input wire logic i_job_start,
  input wire logic [7:0] i_job_addr,
  input wire logic [7:0] i_job_func,
  input wire logic [7:0] i_job_len,
  input wire logic i_data_valid,
  input wire logic [7:0] i_data_byte,
  input wire logic i_tx_ready,
  input wire logic i_tx_busy,
  input wire logic i_rx_valid,
  input wire logic [7:0] i_rx_byte,
  output logic o_ready,
  output logic o_busy,
  output logic o_data_ready,
  output logic o_tx_valid,
  output logic [7:0] o_tx_byte,
  output logic o_line_drive,
  output logic o_rx_data_valid,
  output logic [7:0] o_rx_data_byte,
  output logic o_done,
  output logic o_error,
  output logic [3:0] o_err_code
);
  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  state_type state_reg, state_next;
  logic [3:0] baud_reg, baud_next;
  logic supp_reg, supp_next;
  logic [15:0] wait_reg, wait_next;
  logic [7:0] jaddr_reg, jaddr_next, jfunc_reg, jfunc_next;
  logic [7:0] jlen_reg, jlen_next;
  logic [8:0] cnt_reg, cnt_next, rlen_reg, rlen_next;
  logic [15:0] crc_reg, crc_next;
  logic [15:0] tick_reg, tick_next;
  logic [16:0] timer_reg, timer_next;
  logic [7:0] raddr_reg, raddr_next, rfunc_reg, rfunc_next;
  logic [7:0] rexc_reg, rexc_next;
  logic txv_reg, txv_next, drv_reg, drv_next, dr_reg, dr_next;
  logic [7:0] txb_reg, txb_next, rxb_reg, rxb_next;
  logic rxv_reg, rxv_next, done_reg, done_next, err_reg, err_next;
  logic [3:0] code_reg, code_next;
  logic ready_reg, ready_next, busy_reg, busy_next;
  logic [7:0] rx_buf [0:255];
  logic buf_we;
  logic [7:0] tx_pick, crc_byte, buf_rd;
  logic [15:0] crc_step;
  logic half_tick;
  logic [16:0] silence_lim, wait_lim;
  logic [8:0] data_end, cnt_inc;

  crc16_byte_step u_crc (
    .i_crc(crc_reg),
    .i_byte(crc_byte),
    .o_crc(crc_step)
  );

  // ---------------------------------------------------------------
  // Byte selection
  // ---------------------------------------------------------------
  always_comb begin
    data_end = 9'(jlen_reg) + 9'h002;
    cnt_inc = cnt_reg + 9'h001;
    if (cnt_reg == 9'h000) tx_pick = jaddr_reg;
    else if (cnt_reg == 9'h001) tx_pick = jfunc_reg;
    else if (cnt_reg < data_end) tx_pick = i_data_byte;
    else if (cnt_reg == data_end) tx_pick = crc_reg[7:0];
    else tx_pick = crc_reg[15:8];
    crc_byte = (state_reg == ST_SEND) ? tx_pick : i_rx_byte;
    buf_rd = rx_buf[cnt_reg[7:0]];
    half_tick = (tick_reg == 16'(P_HALF_MS_CYCLES - 1));
    silence_lim = 17'h00001 << baud_reg;
    wait_lim = {wait_reg, 1'b0};
  end

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    baud_next = baud_reg;
    supp_next = supp_reg;
    wait_next = wait_reg;
    jaddr_next = jaddr_reg;
    jfunc_next = jfunc_reg;
    jlen_next = jlen_reg;
    cnt_next = cnt_reg;
    rlen_next = rlen_reg;
    crc_next = crc_reg;
    tick_next = half_tick ? 16'h0000 : tick_reg + 16'h0001;
    timer_next = half_tick ? timer_reg + 17'h00001 : timer_reg;
    raddr_next = raddr_reg;
    rfunc_next = rfunc_reg;
    rexc_next = rexc_reg;
    txv_next = txv_reg;
    txb_next = txb_reg;
    drv_next = 1'b0;
    dr_next = 1'b0;
    rxv_next = 1'b0;
    rxb_next = rxb_reg;
    done_next = 1'b0;
    err_next = 1'b0;
    code_next = code_reg;
    buf_we = 1'b0;
    case (state_reg)
      ST_INIT: if (i_selftest_done) state_next = ST_PARAM;
      ST_PARAM: begin
        if (i_param_load) begin
          baud_next = (i_cfg_baud_sel > BAUD_SEL_MAX) ? BAUD_SEL_MAX
                                                      : i_cfg_baud_sel;
          supp_next = i_cfg_suppress;
          wait_next = i_cfg_reply_ms;
          state_next = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (i_job_start) begin
          jaddr_next = i_job_addr;
          jfunc_next = i_job_func;
          jlen_next = i_job_len;
          cnt_next = 9'h000;
          crc_next = CRC_INIT;
          // Reject before the line is touched
          if (!fc_supported(i_job_func) ||
              (i_job_addr == BCAST_ADDR && !fc_bcast_ok(i_job_func))) begin
            err_next = 1'b1;
            done_next = 1'b1;
            code_next = ERR_REQUEST;
          end else begin
            code_next = ERR_NONE;
            state_next = ST_SEND;
          end
        end
      end
      ST_SEND: begin
        drv_next = 1'b1;
        if (txv_reg) begin
          if (i_tx_ready) begin
            txv_next = 1'b0;
            cnt_next = cnt_inc;
            if (cnt_reg == data_end + 9'h001) state_next = ST_DRAIN;
          end
        end else if (cnt_reg < 9'h002 || cnt_reg >= data_end) begin
          txv_next = 1'b1;
          txb_next = tx_pick;
          if (cnt_reg < data_end) crc_next = crc_step;
        end else if (dr_reg && i_data_valid) begin
          txv_next = 1'b1;
          txb_next = tx_pick;
          crc_next = crc_step;
        end else begin
          dr_next = 1'b1;
        end
      end
      ST_DRAIN: begin
        // Hold the driver until the last stop bit leaves
        drv_next = i_tx_busy;
        if (!i_tx_busy) begin
          cnt_next = 9'h000;
          crc_next = CRC_INIT;
          tick_next = 16'h0000;
          timer_next = 17'h00000;
          if (jaddr_reg == BCAST_ADDR) begin
            done_next = 1'b1;
            state_next = ST_IDLE;
          end else begin
            state_next = ST_WAIT;
          end
        end
      end
      ST_WAIT, ST_RECV: begin
        if (i_rx_valid) begin
          state_next = ST_RECV;
          tick_next = 16'h0000;
          timer_next = 17'h00000;
          crc_next = crc_step;
          // Bytes past the buffer are not stored but still enter the checksum
          if (cnt_reg < RX_DEPTH) begin
            buf_we = 1'b1;
            cnt_next = cnt_inc;
          end
          if (cnt_reg == 9'h000) raddr_next = i_rx_byte;
          if (cnt_reg == 9'h001) rfunc_next = i_rx_byte;
          if (cnt_reg == 9'h002) rexc_next = i_rx_byte;
          if (supp_reg && crc_step == 16'h0000 && cnt_inc >= MIN_FRAME &&
              raddr_reg == jaddr_reg) begin
            state_next = ST_CHECK;
          end
        end else if (state_reg == ST_WAIT) begin
          if (timer_reg >= wait_lim) begin
            err_next = 1'b1;
            done_next = 1'b1;
            code_next = ERR_TIMEOUT;
            state_next = ST_IDLE;
          end
        end else if (timer_reg >= silence_lim) begin
          state_next = ST_CHECK;
        end
      end
      ST_CHECK: begin
        done_next = 1'b1;
        state_next = ST_IDLE;
        if (cnt_reg < MIN_FRAME || crc_reg != 16'h0000) begin
          err_next = 1'b1;
          code_next = ERR_CRC;
        end else if (raddr_reg != jaddr_reg) begin
          err_next = 1'b1;
          code_next = ERR_FRAME;
        end else if (rfunc_reg == (jfunc_reg | EXC_FLAG)) begin
          err_next = 1'b1;
          if (cnt_reg == EXC_FRAME && rexc_reg >= 8'(EXC_MIN) &&
              rexc_reg <= 8'(EXC_MAX)) code_next = rexc_reg[3:0];
          else code_next = ERR_FRAME;
        end else if (rfunc_reg != jfunc_reg) begin
          err_next = 1'b1;
          code_next = ERR_FRAME;
        end else if (cnt_reg > MIN_FRAME) begin
          done_next = 1'b0;
          rlen_next = cnt_reg - 9'h002;
          cnt_next = 9'h002;
          state_next = ST_DELIVER;
        end
      end
      ST_DELIVER: begin
        rxv_next = 1'b1;
        rxb_next = buf_rd;
        cnt_next = cnt_inc;
        if (cnt_inc == rlen_reg) begin
          done_next = 1'b1;
          state_next = ST_IDLE;
        end
      end
      default: state_next = ST_INIT;
    endcase
    ready_next = (state_next == ST_IDLE);
    busy_next = !(state_next == ST_IDLE || state_next == ST_INIT ||
                  state_next == ST_PARAM);
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge i_sys_clk) begin
    if (buf_we) rx_buf[cnt_reg[7:0]] <= i_rx_byte;
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state_reg <= ST_INIT;
      baud_reg <= 4'h0;
      supp_reg <= 1'b0;
      wait_reg <= 16'h0000;
      jaddr_reg <= 8'h00;
      jfunc_reg <= 8'h00;
      jlen_reg <= 8'h00;
      cnt_reg <= 9'h000;
      rlen_reg <= 9'h000;
      crc_reg <= CRC_INIT;
      tick_reg <= 16'h0000;
      timer_reg <= 17'h00000;
      raddr_reg <= 8'h00;
      rfunc_reg <= 8'h00;
      rexc_reg <= 8'h00;
      txv_reg <= 1'b0;
      txb_reg <= 8'h00;
      drv_reg <= 1'b0;
      dr_reg <= 1'b0;
      rxv_reg <= 1'b0;
      rxb_reg <= 8'h00;
      done_reg <= 1'b0;
      err_reg <= 1'b0;
      code_reg <= ERR_NONE;
      ready_reg <= 1'b0;
      busy_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      baud_reg <= baud_next;
      supp_reg <= supp_next;
      wait_reg <= wait_next;
      jaddr_reg <= jaddr_next;
      jfunc_reg <= jfunc_next;
      jlen_reg <= jlen_next;
      cnt_reg <= cnt_next;
      rlen_reg <= rlen_next;
      crc_reg <= crc_next;
      tick_reg <= tick_next;
      timer_reg <= timer_next;
      raddr_reg <= raddr_next;
      rfunc_reg <= rfunc_next;
      rexc_reg <= rexc_next;
      txv_reg <= txv_next;
      txb_reg <= txb_next;
      drv_reg <= drv_next;
      dr_reg <= dr_next;
      rxv_reg <= rxv_next;
      rxb_reg <= rxb_next;
      done_reg <= done_next;
      err_reg <= err_next;
      code_reg <= code_next;
      ready_reg <= ready_next;
      busy_reg <= busy_next;
    end
  end

  assign o_ready = ready_reg;
  assign o_busy = busy_reg;
  assign o_data_ready = dr_reg;
  assign o_tx_valid = txv_reg;
  assign o_tx_byte = txb_reg;
  assign o_line_drive = drv_reg;
  assign o_rx_data_valid = rxv_reg;
  assign o_rx_data_byte = rxb_reg;
  assign o_done = done_reg;
  assign o_error = err_reg;
  assign o_err_code = code_reg;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  a_bcast_write_only: assert property (@(posedge i_sys_clk)
    disable iff (!i_resetn) state_reg == ST_SEND |->
    (jaddr_reg != BCAST_ADDR || fc_bcast_ok(jfunc_reg)) &&
    fc_supported(jfunc_reg))
    else $error("illegal request reached the line");
  a_bcast_no_wait: assert property (@(posedge i_sys_clk)
    disable iff (!i_resetn) state_reg == ST_DRAIN && !i_tx_busy &&
    jaddr_reg == BCAST_ADDR |=> state_reg == ST_IDLE && o_done && !o_error)
    else $error("broadcast waited for a reply");
  a_unicast_waits: assert property (@(posedge i_sys_clk)
    disable iff (!i_resetn) state_reg == ST_DRAIN && !i_tx_busy &&
    jaddr_reg != BCAST_ADDR |=> state_reg == ST_WAIT && timer_reg == 17'h00000)
    else $error("unicast did not wait for reply");
  a_crc_low_first: assert property (@(posedge i_sys_clk)
    disable iff (!i_resetn) state_reg == ST_SEND && o_tx_valid &&
    cnt_reg == data_end |-> o_tx_byte == crc_reg[7:0])
    else $error("checksum low byte not first");
  a_crc_high_last: assert property (@(posedge i_sys_clk)
    disable iff (!i_resetn) state_reg == ST_SEND && o_tx_valid &&
    cnt_reg == data_end + 9'h001 && i_tx_ready |=> state_reg == ST_DRAIN)
    else $error("frame did not end after checksum high byte");
  a_exc_no_data: assert property (@(posedge i_sys_clk)
    disable iff (!i_resetn) state_reg == ST_CHECK && crc_reg == 16'h0000 &&
    cnt_reg == EXC_FRAME && raddr_reg == jaddr_reg &&
    rfunc_reg == (jfunc_reg | EXC_FLAG) |=> o_error && o_done &&
    (o_err_code == rexc_reg[3:0] || o_err_code == ERR_FRAME)
    ##1 !o_rx_data_valid)
    else $error("exception reply not reported as error");
  a_reply_timeout: assert property (@(posedge i_sys_clk)
    disable iff (!i_resetn) state_reg == ST_WAIT && !i_rx_valid &&
    timer_reg >= wait_lim |=> o_error && o_err_code == ERR_TIMEOUT && o_ready)
    else $error("reply timeout not flagged");
  a_silence_end: assert property (@(posedge i_sys_clk)
    disable iff (!i_resetn) state_reg == ST_RECV && !supp_reg &&
    (i_rx_valid || timer_reg < silence_lim) |=> state_reg != ST_CHECK)
    else $error("frame checked before line silence");
  a_not_ready_early: assert property (@(posedge i_sys_clk)
    disable iff (!i_resetn) (state_reg == ST_INIT || state_reg == ST_PARAM)
    |-> !o_ready && !o_busy)
    else $error("ready before start-up finished");
  a_half_duplex: assert property (@(posedge i_sys_clk)
    disable iff (!i_resetn) o_line_drive |->
    $past(state_reg) == ST_SEND || $past(state_reg) == ST_DRAIN)
    else $error("line driven while receiving");
endmodule // modbus_rtu_master_framer
`default_nettype wire

// [modbus_slave_model.sv]
// Slave-side partner model for the RTU master framer
`timescale 1ns/10ps
`default_nettype none
module modbus_slave_model (
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  input wire logic i_tx_valid,
  input wire logic [7:0] i_tx_byte,
  input wire logic i_line_drive,
  output logic o_tx_ready,
  output logic o_tx_busy,
  output logic o_rx_valid,
  output logic [7:0] o_rx_byte
);
  // Reply kind: 0 data, 1 exception, 2 silent, 3 corrupt checksum
  int mode = 0;
  int gap = 3;
  logic [7:0] exc = 8'h01;
  logic [7:0] rsp[$];
  logic [7:0] req[$];
  logic [7:0] frm[$];
  logic [15:0] crc;
  logic [2:0] shift_cnt;

  function automatic logic [15:0] crc_calc(input logic [7:0] q[$]);
    logic [15:0] c;
    c = 16'hFFFF;
    foreach (q[i]) begin
      c ^= {8'h00, q[i]};
      for (int b = 0; b < 8; b++)
        c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
    end
    return c;
  endfunction

  // ---------------------------------------------------------------
  // Character transmitter: slow accept, then busy while shifting
  // ---------------------------------------------------------------
  always @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_tx_ready <= 1'b0;
      shift_cnt <= 3'h0;
    end else begin
      o_tx_ready <= i_tx_valid && !o_tx_ready && shift_cnt == 3'h0;
      if (i_tx_valid && o_tx_ready) begin
        req.push_back(i_tx_byte);
        shift_cnt <= 3'h4;
      end else if (shift_cnt != 3'h0) begin
        shift_cnt <= shift_cnt - 3'h1;
      end
    end
  end
  assign o_tx_busy = shift_cnt != 3'h0;

  // ---------------------------------------------------------------
  // Reply: only once the master has released the line
  // ---------------------------------------------------------------
  initial begin
    o_rx_valid = 1'b0;
    o_rx_byte = 8'h00;
    forever begin
      @(negedge i_line_drive);
      if (req.size() > 1 && req[0] != 8'h00 && mode != 2) begin
        frm = {req[0], mode == 1 ? (req[1] | 8'h80) : req[1]};
        if (mode == 1) frm.push_back(exc);
        else frm = {frm, rsp};
        crc = crc_calc(frm);
        frm = {frm, crc[7:0] ^ (mode == 3 ? 8'h01 : 8'h00), crc[15:8]};
        repeat (5) @(posedge i_sys_clk);
        foreach (frm[i]) begin
          o_rx_valid <= 1'b1;
          o_rx_byte <= frm[i];
          @(posedge i_sys_clk);
          // Idle data never repeats the last byte
          o_rx_valid <= 1'b0;
          o_rx_byte <= ~frm[i];
          repeat (gap) @(posedge i_sys_clk);
        end
      end
      req.delete();
    end
  end
endmodule // modbus_slave_model
`default_nettype wire

// [testbench.sv]
// Self-checking testbench for the RTU master framer
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import modbus_rtu_pkg::*;
  // Short half-ms tick keeps silences and reply waits brief
  localparam int HMS = 10;
  localparam logic [7:0] FCS [12] = '{FC_RD_COILS, FC_RD_INPUTS,
    FC_RD_HOLD, FC_RD_INREG, FC_WR_COIL, FC_WR_REG, FC_RD_EXC,
    FC_LOOPBACK, FC_EVT_CNT, FC_EVT_LOG, FC_WR_COILS, FC_WR_REGS};
  localparam logic [7:0] WRS [4] = '{FC_WR_COIL, FC_WR_REG,
    FC_WR_COILS, FC_WR_REGS};
  logic i_sys_clk = 1'b0;
  logic i_resetn = 1'b0;
  logic i_selftest_done = 1'b0;
  logic i_param_load = 1'b0;
  logic [3:0] i_cfg_baud_sel = 4'h0;
  logic i_cfg_suppress = 1'b0;
  logic [15:0] i_cfg_reply_ms = 16'h0002;
  logic i_job_start = 1'b0;
  logic [7:0] i_job_addr = 8'h00;
  logic [7:0] i_job_func = 8'h00;
  logic [7:0] i_job_len = 8'h00;
  logic i_data_valid = 1'b0;
  logic [7:0] i_data_byte = 8'h00;
  logic i_tx_ready, i_tx_busy, i_rx_valid;
  logic [7:0] i_rx_byte, o_tx_byte, o_rx_data_byte;
  logic o_ready, o_busy, o_data_ready, o_tx_valid, o_line_drive;
  logic o_rx_data_valid, o_done, o_error, err_seen;
  logic [3:0] o_err_code;
  int miscompares = 0;
  int n_tests = 0;
  int cyc = 0, didx = 0, t_rel = 0, t_rx = 0, t_done = 0, sil = 0;
  logic [7:0] dat[$], txq[$], rxq[$], xq[$];

  modbus_rtu_master_framer #(.P_HALF_MS_CYCLES(HMS))
    modbus_rtu_master_framer_inst (.i_sys_clk(i_sys_clk),
    .i_resetn(i_resetn), .i_selftest_done(i_selftest_done),
    .i_param_load(i_param_load), .i_cfg_baud_sel(i_cfg_baud_sel),
    .i_cfg_suppress(i_cfg_suppress), .i_cfg_reply_ms(i_cfg_reply_ms),
    .i_job_start(i_job_start), .i_job_addr(i_job_addr),
    .i_job_func(i_job_func), .i_job_len(i_job_len),
    .i_data_valid(i_data_valid), .i_data_byte(i_data_byte),
    .i_tx_ready(i_tx_ready), .i_tx_busy(i_tx_busy),
    .i_rx_valid(i_rx_valid), .i_rx_byte(i_rx_byte), .o_ready(o_ready),
    .o_busy(o_busy), .o_data_ready(o_data_ready),
    .o_tx_valid(o_tx_valid), .o_tx_byte(o_tx_byte),
    .o_line_drive(o_line_drive), .o_rx_data_valid(o_rx_data_valid),
    .o_rx_data_byte(o_rx_data_byte), .o_done(o_done),
    .o_error(o_error), .o_err_code(o_err_code));
  modbus_slave_model slave_inst (.i_sys_clk(i_sys_clk),
    .i_resetn(i_resetn), .i_tx_valid(o_tx_valid), .i_tx_byte(o_tx_byte),
    .i_line_drive(o_line_drive), .o_tx_ready(i_tx_ready),
    .o_tx_busy(i_tx_busy), .o_rx_valid(i_rx_valid), .o_rx_byte(i_rx_byte));

  initial forever #5 i_sys_clk = ~i_sys_clk;

  // ---------------------------------------------------------------
  // Monitors and request data feeder
  // ---------------------------------------------------------------
  always @(posedge i_sys_clk) begin
    cyc <= cyc + 1;
    if (o_tx_valid && i_tx_ready) txq.push_back(o_tx_byte);
    if (o_rx_data_valid) rxq.push_back(o_rx_data_byte);
    if (i_data_valid && o_data_ready) didx <= didx + 1;
    if (i_rx_valid) t_rx <= cyc;
    if ($fell(o_line_drive)) t_rel <= cyc;
  end
  always @(negedge i_sys_clk) begin
    i_data_valid <= o_data_ready && didx < dat.size();
    i_data_byte <= didx < dat.size() ? dat[didx] : 8'h00;
  end

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic conclude();
    $display("tests %0d miscompares %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic wait_done(input int lim);
    int k;
    k = 0;
    while (o_done !== 1'b1 && k < lim) begin
      @(negedge i_sys_clk);
      k++;
    end
    if (k >= lim) begin
      miscompares++;
      $display("BAD done exp 1 got 0");
      conclude();
    end
    err_seen = o_error;
    t_done = cyc;
  endtask

  task automatic start_up(input logic [3:0] sel, input logic sup);
    i_resetn = 1'b0;
    i_selftest_done = 1'b0;
    repeat (5) @(negedge i_sys_clk);
    i_resetn = 1'b1;
    i_cfg_baud_sel = sel;
    i_cfg_suppress = sup;
    sil = HMS << sel;
    // A parameter pulse before the self test ends must be ignored
    i_param_load = 1'b1;
    @(negedge i_sys_clk);
    i_param_load = 1'b0;
    repeat (2) @(negedge i_sys_clk);
    chk("ready_early", 16'h0, {15'h0, o_ready});
    i_selftest_done = 1'b1;
    repeat (3) @(negedge i_sys_clk);
    chk("ready_no_param", 16'h0, {15'h0, o_ready});
    i_param_load = 1'b1;
    @(negedge i_sys_clk);
    i_param_load = 1'b0;
    @(negedge i_sys_clk);
    chk("ready_up", 16'h1, {15'h0, o_ready});
  endtask

  task automatic job(input logic [7:0] a, f, input int n, m,
                     input logic [3:0] e);
    logic [15:0] c;
    int nr;
    dat.delete();
    txq.delete();
    rxq.delete();
    slave_inst.rsp.delete();
    didx = 0;
    for (int i = 0; i < n; i++) dat.push_back(8'($urandom));
    nr = $urandom_range(3);
    for (int i = 0; i < nr; i++) slave_inst.rsp.push_back(8'($urandom));
    slave_inst.mode = m;
    slave_inst.exc = 8'(e);
    slave_inst.gap = $urandom_range(5, 1);
    chk("ready_idle", 16'h1, {15'h0, o_ready});
    i_job_addr = a;
    i_job_func = f;
    i_job_len = 8'(n);
    i_job_start = 1'b1;
    @(negedge i_sys_clk);
    i_job_start = 1'b0;
    chk("busy", {15'h0, e != ERR_REQUEST}, {15'h0, o_busy});
    wait_done(4000);
    repeat (2) @(negedge i_sys_clk);
    chk("err_code", {12'h0, e}, {12'h0, o_err_code});
    chk("err_flag", {15'h0, e != ERR_NONE}, {15'h0, err_seen});
    xq.delete();
    if (e != ERR_REQUEST) begin
      xq = {a, f, dat};
      c = slave_inst.crc_calc(xq);
      xq = {xq, c[7:0], c[15:8]};
    end
    chk("tx_len", 16'(xq.size()), 16'(txq.size()));
    foreach (xq[i]) chk("tx_byte", {8'h0, xq[i]}, {8'h0, txq[i]});
    xq.delete();
    if (m == 0 && e == ERR_NONE && a != BCAST_ADDR) xq = slave_inst.rsp;
    chk("rx_len", 16'(xq.size()), 16'(rxq.size()));
    foreach (xq[i]) chk("rx_byte", {8'h0, xq[i]}, {8'h0, rxq[i]});
    $display("job addr %h func %h code %h ended", a, f, e);
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    void'($urandom(32'hBD53));
    start_up(4'($urandom_range(3, 1)), 1'b0);
    foreach (FCS[i]) begin
      job(8'($urandom_range(255, 1)), FCS[i], $urandom_range(4), 0,
          ERR_NONE);
      chk("silence_end", 16'h1,
          16'(t_done - t_rx >= sil - 10 && t_done - t_rx <= sil + 14));
    end
    job(8'hFF, FC_RD_HOLD, 4, 0, ERR_NONE);
    job(8'h01, FC_LOOPBACK, 4, 0, ERR_NONE);
    foreach (WRS[i]) begin
      job(BCAST_ADDR, WRS[i], 4, 0, ERR_NONE);
      chk("bcast_no_wait", 16'h1, 16'(t_done - t_rel <= 3));
    end
    job(BCAST_ADDR, FC_RD_HOLD, 2, 0, ERR_REQUEST);
    job(8'h11, 8'h09, 2, 0, ERR_REQUEST);
    for (int x = 1; x <= 7; x++) job(8'h22, FC_RD_INREG, 4, 1, 4'(x));
    job(8'h22, FC_RD_INREG, 1, 1, ERR_FRAME);
    job(8'h33, FC_RD_COILS, 4, 2, ERR_TIMEOUT);
    chk("reply_wait", 16'h1,
        16'(t_done - t_rel >= 28 && t_done - t_rel <= 54));
    job(8'h44, FC_RD_HOLD, 4, 3, ERR_CRC);
    start_up(4'h3, 1'b1);
    job(8'h55, FC_EVT_LOG, 0, 0, ERR_NONE);
    chk("fast_end", 16'h1,
        16'(t_done - t_rx <= 2 + slave_inst.rsp.size()));
    conclude();
  end
endmodule // testbench
`default_nettype wire
